// *** inc/shpi_pkg.sv ***
// package of constants for the servo head position interface
package shpi_pkg;
	// ************************************************************
	// register map (byte addresses, one aligned word each)
	// ************************************************************
	localparam logic [7:0] ADDR_CTRL = 8'h00; // control bits
	localparam logic [7:0] ADDR_DIST = 8'h04; // distance register
	localparam logic [7:0] ADDR_SKEWW = 8'h08; // skew word
	localparam logic [7:0] ADDR_SKEWV = 8'h0c; // skew measure value
	localparam logic [7:0] ADDR_STAT = 8'h10; // status bits
	localparam logic [7:0] ADDR_CMD = 8'h14; // one-shot commands
	localparam logic [7:0] ADDR_OFST = 8'h18; // head alignment offset
	// ************************************************************
	// control register fields
	// ************************************************************
	localparam int CTRL_ASEL_LO = 0; // analog_select 2:0
	localparam int CTRL_LNGSK = 3; // long_seek_flag
	localparam int CTRL_PARITY = 4; // track_parity_bit
	localparam int CTRL_AMPDIS = 5; // amp_disable
	localparam int CTRL_TEMPSEL = 6; // temp_source_select
	localparam int CTRL_LOOPEN_N = 7; // position_loop_enable_n
	localparam int CTRL_STEST_N = 8; // position_selftest_n
	localparam int CTRL_QTCEN = 9; // quarter-track clocking of distance
	localparam int CTRL_PROF_LO = 10; // profile_select 11:10
	localparam int CTRL_SEEK = 12; // seeking (coarse position)
	localparam int CTRL_SKWST = 13; // skew_measure_start
	localparam int CTRL_WIDTH = 14;
	localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 14'h0180; // loop off, selftest off
	// ************************************************************
	// command register bits (write one to pulse)
	// ************************************************************
	localparam int CMD_OTCLR = 0; // off_track_clear
	localparam int CMD_ERRCLR = 1; // error_clear
	localparam int CMD_RETRACT = 2; // cpu_retract_request
	// ************************************************************
	// status register fields
	// ************************************************************
	localparam int STAT_OFTRK = 0;
	localparam int STAT_SYNC = 1;
	localparam int STAT_SKMFLG = 2;
	localparam int STAT_CLIM_N = 3;
	localparam int STAT_AMPEN = 4;
	localparam int STAT_RETR = 5;
	localparam int STAT_PARITY = 6;
	localparam int STAT_SOSP = 7;
	// ************************************************************
	// constants
	// ************************************************************
	localparam logic [7:0] SKEW_ZERO = 8'h80; // counter value at zero skew
	localparam logic [1:0] PROF_FAST = 2'b00;
	localparam logic [1:0] PROF_HALF = 2'b01;
	localparam logic [1:0] PROF_QUART = 2'b10;
	localparam logic [1:0] PROF_SLOW = 2'b11;
	localparam int DIST_WIDTH = 11;
	localparam logic [31:0] RDATA_NONE = 32'h0000_0000;
endpackage : shpi_pkg

// *** hdl/shpi_top.sv ***
// servo head position interface: apb registers, latches and skew timing
// Behaviour
// - track parity drives error polarity, read back
// - master reset clears all interface state except the apb response, strobes and synchronisers
// - analog_select routes one of eight sources
// - off track latch sets after settling
// - off_track_clear resets off track latch
// - amp_disable or emergency disables amplifier
// - retract request starts emergency retract
// - temp_source_select picks coil or exhaust sensor
// - position from coarse, fine or offset
// - self test routes offset to position
// - current limit flag low beyond +-1.4V
// - quarter track pulse clocks distance register
// - read strobes for registers 0,1,3,6
// - write strobes for registers 0 to 6
// - profile_select picks one of four profiles
// - sync seen flag held until error_clear
// - skew flag set until data clock, test or skew_measure_start cleared
// - skew start waits for next data clock
// - data clock latches counter, zero is 80
// - skew word match emits sector start pulse
// - error_clear resets sector presence flip-flop
// - distance register eleven bits, preload, readback
`timescale 1ns/1ps
module shpi_top
	import shpi_pkg::*;
#(
	parameter int CNT_WIDTH = 8 // intra-sector counter width
)(
	input wire logic clk,
	input wire logic reset,
	input wire logic masterReset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic offTrackEvent,
	input wire logic sectorSyncIn,
	input wire logic dataClockPulse,
	input wire logic quarterTrackPulse,
	input wire logic currentOverPos,
	input wire logic currentUnderNeg,
	input wire logic emergencyCond,
	input wire logic emergencyLatch,
	input wire logic selfTestCond,
	output logic [2:0] analogSelect,
	output logic longSeekFlag,
	output logic trackParityBit,
	output logic tempSourceSelect,
	output logic positionLoopEnable_n,
	output logic [1:0] profileSelect,
	output logic [1:0] positionSource,
	output logic ampEnable,
	output logic cpuRetractRequest_n,
	output logic [DIST_WIDTH-1:0] distanceRegister,
	output logic [7:0] headAlignOffset,
	output logic sectorStartPulse,
	output logic [7:0] regReadStrobe_n,
	output logic [6:0] regWriteStrobe_n
);
	// ************************************************************
	// elaboration checks
	// ************************************************************
	if (CNT_WIDTH != 8)
		$error("skew counter must be eight bits");

	// ************************************************************
	// input synchronisers
	// ************************************************************
	localparam int NSYNC = 9;
	logic [NSYNC-1:0] syncA_q; // first stage, read only by second
	logic [NSYNC-1:0] syncB_q; // second stage, safe to use
	logic [NSYNC-1:0] syncPrev_q; // for edge detection
	// pins from analog side are asynchronous to clk
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			// master reset bit starts at its idle high level, no false clear
			syncA_q <= {1'b1, {(NSYNC-1){1'b0}}};
			syncB_q <= {1'b1, {(NSYNC-1){1'b0}}};
			syncPrev_q <= {1'b1, {(NSYNC-1){1'b0}}};
		end
		else
		begin
			syncA_q <= {masterReset_n, offTrackEvent, sectorSyncIn, dataClockPulse,
				quarterTrackPulse, currentOverPos, currentUnderNeg, emergencyCond,
				emergencyLatch};
			syncB_q <= syncA_q;
			syncPrev_q <= syncB_q;
		end
	end
	logic mrstN;
	logic offEvt;
	logic syncRise;
	logic dcpRise;
	logic qtcRise;
	logic overPos;
	logic underNeg;
	logic emerg;
	logic emLatch;
	assign mrstN = syncB_q[8];
	assign offEvt = syncB_q[7];
	assign syncRise = syncB_q[6] & ~syncPrev_q[6];
	assign dcpRise = syncB_q[5] & ~syncPrev_q[5];
	assign qtcRise = syncB_q[4] & ~syncPrev_q[4];
	assign overPos = syncB_q[3];
	assign underNeg = syncB_q[2];
	assign emerg = syncB_q[1];
	assign emLatch = syncB_q[0];
	// self test condition gets its own pair
	logic stA_q;
	logic stB_q;
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			stA_q <= 1'b0;
			stB_q <= 1'b0;
		end
		else
		begin
			stA_q <= selfTestCond;
			stB_q <= stA_q;
		end
	end
	// master reset acts synchronously after the synchroniser
	logic clr;
	assign clr = ~mrstN;

	// ************************************************************
	// apb decode
	// ************************************************************
	// map address to register index, 7 means unmapped
	function automatic logic [2:0] regIndex(input logic [7:0] a);
		unique case (a)
			ADDR_CTRL: regIndex = 3'd0;
			ADDR_DIST: regIndex = 3'd1;
			ADDR_SKEWW: regIndex = 3'd2;
			ADDR_SKEWV: regIndex = 3'd3;
			ADDR_STAT: regIndex = 3'd4;
			ADDR_CMD: regIndex = 3'd5;
			ADDR_OFST: regIndex = 3'd6;
			default: regIndex = 3'd7;
		endcase
	endfunction : regIndex
	logic acc;
	logic wrAcc;
	logic rdAcc;
	logic [2:0] idx;
	logic mapped;
	assign acc = psel & penable;
	assign wrAcc = acc & pwrite;
	assign rdAcc = acc & ~pwrite;
	assign idx = regIndex(paddr);
	assign mapped = (idx != 3'd7);

	// ************************************************************
	// control registers
	// ************************************************************
	logic [CTRL_WIDTH-1:0] ctrl_q;
	logic [7:0] skewWord_q;
	logic [7:0] offset_q;
	// controls hold until rewritten or master reset
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			ctrl_q <= CTRL_RESET;
			skewWord_q <= '0;
			offset_q <= '0;
		end
		else if (clr)
		begin
			ctrl_q <= CTRL_RESET;
			skewWord_q <= '0;
			offset_q <= '0;
		end
		else if (wrAcc)
		begin
			// write captures bus data
			if (idx == 3'd0)
				ctrl_q <= pwdata[CTRL_WIDTH-1:0];
			if (idx == 3'd2)
				skewWord_q <= pwdata[7:0];
			if (idx == 3'd6)
				offset_q <= pwdata[7:0];
		end
	end
	logic cmdOtClr;
	logic cmdErrClr;
	logic cmdRetract;
	assign cmdOtClr = wrAcc & (idx == 3'd5) & pwdata[CMD_OTCLR];
	assign cmdErrClr = wrAcc & (idx == 3'd5) & pwdata[CMD_ERRCLR];
	assign cmdRetract = wrAcc & (idx == 3'd5) & pwdata[CMD_RETRACT];

	// ************************************************************
	// analog steering outputs
	// ************************************************************
	// processor policy bits (long seek, loop enable) just pass out registered
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			analogSelect <= '0;
			longSeekFlag <= 1'b0;
			trackParityBit <= 1'b0;
			tempSourceSelect <= 1'b0;
			positionLoopEnable_n <= 1'b1;
			profileSelect <= PROF_FAST;
			positionSource <= 2'd0;
			headAlignOffset <= '0;
		end
		else
		begin
			analogSelect <= ctrl_q[CTRL_ASEL_LO +: 3];
			longSeekFlag <= ctrl_q[CTRL_LNGSK];
			trackParityBit <= ctrl_q[CTRL_PARITY];
			tempSourceSelect <= ctrl_q[CTRL_TEMPSEL];
			positionLoopEnable_n <= ctrl_q[CTRL_LOOPEN_N];
			profileSelect <= ctrl_q[CTRL_PROF_LO +: 2];
			headAlignOffset <= offset_q;
			// 2 offset (self test), 1 coarse (seek), 0 fine (on track)
			if (!ctrl_q[CTRL_STEST_N])
				positionSource <= 2'd2;
			else if (ctrl_q[CTRL_SEEK])
				positionSource <= 2'd1;
			else
				positionSource <= 2'd0;
		end
	end

	// ************************************************************
	// amplifier and retract
	// ************************************************************
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			ampEnable <= 1'b0;
			cpuRetractRequest_n <= 1'b1;
		end
		else
		begin
			// safe default: disabled on any doubt
			ampEnable <= ~ctrl_q[CTRL_AMPDIS] & ~emLatch & ~emerg & ~clr;
			// one-cycle active-low request
			cpuRetractRequest_n <= ~(cmdRetract & ~clr);
		end
	end

	// ************************************************************
	// off track and sync latches
	// ************************************************************
	logic offTrack_q;
	logic syncSeen_q;
	logic climN_q;
	// set wins over off_track_clear or error_clear in the same cycle; master reset wins over set
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			offTrack_q <= 1'b0;
			syncSeen_q <= 1'b0;
			climN_q <= 1'b1;
		end
		else if (clr)
		begin
			offTrack_q <= 1'b0;
			syncSeen_q <= 1'b0;
			climN_q <= 1'b1;
		end
		else
		begin
			if (offEvt & ~ctrl_q[CTRL_SEEK])
				offTrack_q <= 1'b1;
			else if (cmdOtClr)
				offTrack_q <= 1'b0;
			if (syncRise)
				syncSeen_q <= 1'b1;
			else if (cmdErrClr)
				syncSeen_q <= 1'b0;
			climN_q <= ~(overPos | underNeg);
		end
	end

	// ************************************************************
	// distance register
	// ************************************************************
	// preload by write; counts down one per quarter track when enabled
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			distanceRegister <= '0;
		else if (clr)
			distanceRegister <= '0;
		else if (wrAcc & (idx == 3'd1))
			distanceRegister <= pwdata[DIST_WIDTH-1:0];
		else if (qtcRise & ctrl_q[CTRL_QTCEN] & (distanceRegister != '0))
			distanceRegister <= distanceRegister - 1'b1;
	end

	// ************************************************************
	// skew measurement and start of sector
	// ************************************************************
	typedef enum logic [1:0] {SK_IDLE = 2'b01, SK_WAIT = 2'b10} shpi_skew_t;
	shpi_skew_t skew_q;
	logic skStartPrev_q;
	logic [7:0] sectCnt_q; // free-running intra-sector counter
	logic [7:0] skewVal_q;
	logic sosp_q;
	logic skStartRise;
	assign skStartRise = ctrl_q[CTRL_SKWST] & ~skStartPrev_q;
	// counter restarts at sync so zero skew reads as 80
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			sectCnt_q <= '0;
		else if (clr)
			sectCnt_q <= '0;
		else if (syncRise)
			sectCnt_q <= SKEW_ZERO;
		else
			sectCnt_q <= sectCnt_q + 1'b1;
	end
	// measurement sequencer
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			skew_q <= SK_IDLE;
			skStartPrev_q <= 1'b0;
			skewVal_q <= '0;
		end
		else if (clr)
		begin
			skew_q <= SK_IDLE;
			skStartPrev_q <= 1'b0;
			skewVal_q <= '0;
		end
		else
		begin
			skStartPrev_q <= ctrl_q[CTRL_SKWST];
			unique case (skew_q)
				SK_IDLE:
				begin
					if (skStartRise)
						skew_q <= SK_WAIT;
				end
				SK_WAIT:
				begin
					if (!ctrl_q[CTRL_SKWST] || stB_q)
						skew_q <= SK_IDLE;
					else if (dcpRise)
					begin
						// data clock with the sync edge is zero skew
						skewVal_q <= syncRise ? SKEW_ZERO : sectCnt_q;
						skew_q <= SK_IDLE;
					end
				end
			endcase
		end
	end
	// sector start pulse and its presence flip-flop
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			sectorStartPulse <= 1'b0;
			sosp_q <= 1'b0;
		end
		else if (clr)
		begin
			sectorStartPulse <= 1'b0;
			sosp_q <= 1'b0;
		end
		else
		begin
			sectorStartPulse <= (sectCnt_q == skewWord_q);
			if (sectorStartPulse)
				sosp_q <= 1'b1;
			else if (cmdErrClr)
				sosp_q <= 1'b0;
		end
	end

	// ************************************************************
	// strobes and read data
	// ************************************************************
	logic [31:0] rd;
	always_comb
	begin
		rd = RDATA_NONE;
		unique case (idx)
			3'd0: rd[CTRL_WIDTH-1:0] = ctrl_q;
			3'd1: rd[DIST_WIDTH-1:0] = distanceRegister;
			3'd2: rd[7:0] = skewWord_q;
			3'd3: rd[7:0] = skewVal_q;
			3'd4:
			begin
				rd[STAT_OFTRK] = offTrack_q;
				rd[STAT_SYNC] = syncSeen_q;
				rd[STAT_SKMFLG] = (skew_q == SK_WAIT);
				rd[STAT_CLIM_N] = climN_q;
				rd[STAT_AMPEN] = ampEnable;
				rd[STAT_RETR] = ~cpuRetractRequest_n;
				rd[STAT_PARITY] = trackParityBit;
				rd[STAT_SOSP] = sosp_q;
			end
			3'd6: rd[7:0] = offset_q;
			default: rd = RDATA_NONE;
		endcase
	end
	// zero-wait slave; strobes mirror the access phase one cycle late
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			prdata <= RDATA_NONE;
			pready <= 1'b0;
			pslverr <= 1'b0;
			regReadStrobe_n <= '1;
			regWriteStrobe_n <= '1;
		end
		else
		begin
			pready <= psel & ~penable; // answer in access cycle
			pslverr <= psel & ~penable & ~(regIndex(paddr) != 3'd7);
			prdata <= (psel & ~penable & ~pwrite) ? rd : RDATA_NONE;
			regReadStrobe_n <= '1;
			regWriteStrobe_n <= '1;
			if (rdAcc & pready & mapped & (idx != 3'd2) & (idx != 3'd4) & (idx != 3'd5))
				regReadStrobe_n[idx] <= 1'b0;
			if (wrAcc & pready & mapped)
				regWriteStrobe_n[idx] <= 1'b0;
		end
	end
	// status of skew flag, held until data clock, test or skew_measure_start cleared
	logic skewFlag;
	assign skewFlag = (skew_q == SK_WAIT);

	// ************************************************************
	// assertions
	// ************************************************************
	property p_offclr;
		@(posedge clk) disable iff (reset)
		(cmdOtClr & pready & ~offEvt & ~clr) |=> !offTrack_q;
	endproperty
	a_offclr: assert property (p_offclr) else $error("off track not cleared");
	property p_offset;
		@(posedge clk) disable iff (reset)
		(offEvt & ~ctrl_q[CTRL_SEEK] & ~clr) |=> offTrack_q;
	endproperty
	a_offset: assert property (p_offset) else $error("off track not set");
	property p_amp;
		@(posedge clk) disable iff (reset)
		ctrl_q[CTRL_AMPDIS] |=> !ampEnable;
	endproperty
	a_amp: assert property (p_amp) else $error("amplifier enabled while disabled");
	property p_clim;
		@(posedge clk) disable iff (reset)
		(overPos & ~clr) |=> !climN_q;
	endproperty
	a_clim: assert property (p_clim) else $error("current limit flag missed");
	property p_sync;
		@(posedge clk) disable iff (reset)
		(syncRise & ~clr) |=> syncSeen_q;
	endproperty
	a_sync: assert property (p_sync) else $error("sync seen not set");
	property p_sos;
		@(posedge clk) disable iff (reset)
		(sectCnt_q == skewWord_q) && !clr |=> sectorStartPulse;
	endproperty
	a_sos: assert property (p_sos) else $error("sector start missed");
	property p_skew;
		@(posedge clk) disable iff (reset)
		(skewFlag & dcpRise & ctrl_q[CTRL_SKWST] & ~stB_q & ~clr)
		|=> (skewVal_q == ($past(syncRise) ? SKEW_ZERO : $past(sectCnt_q)));
	endproperty
	a_skew: assert property (p_skew) else $error("skew value not latched");
	property p_selftest;
		@(posedge clk) disable iff (reset)
		!ctrl_q[CTRL_STEST_N] |=> (positionSource == 2'd2);
	endproperty
	a_selftest: assert property (p_selftest) else $error("self test source wrong");
	property p_mrst;
		@(posedge clk) disable iff (reset)
		clr |=> (ctrl_q == CTRL_RESET) && !offTrack_q;
	endproperty
	a_mrst: assert property (p_mrst) else $error("master reset did not clear");
endmodule : shpi_top

// *** bench/shpi_cpu_model.sv ***
// processor-side model: apb master and control word builders
`timescale 1ns/1ps
module shpi_cpu_model
	import shpi_pkg::*;
(
	input wire logic clk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	// ************************************************************
	// bus master
	// ************************************************************
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
	end
	// one transfer; request held until pready is seen high or 16 edges pass
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic err, output logic ok);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		ok = 1'b0;
		for (n = 0; n < 16 && !ok; n++)
		begin
			@(posedge clk);
			ok = (pready === 1'b1);
		end
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
	// seek: loop open, long seek from 33 tracks, parity from track lsb
	function automatic logic [31:0] seek_bits(input int tracks, input int trk);
		seek_bits = 32'h0000_0180 | (1 << CTRL_SEEK);
		seek_bits[CTRL_LNGSK] = (tracks >= 33);
		seek_bits[CTRL_PARITY] = trk[0];
	endfunction : seek_bits
	// track following: loop enable low, seek bit clear
	function automatic logic [31:0] follow_bits(input int trk);
		follow_bits = 32'h0000_0100;
		follow_bits[CTRL_PARITY] = trk[0];
	endfunction : follow_bits
endmodule : shpi_cpu_model

// *** bench/shpi_top_tb_top.sv ***
// self-checking bench for the servo head position interface
`timescale 1ns/1ps
module shpi_top_tb_top;
	import shpi_pkg::*;
	// ************************************************************
	// signals
	// ************************************************************
	logic clk, reset, masterReset_n, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr, headAlignOffset, rdStb, regReadStrobe_n, skewSeen;
	logic [31:0] pwdata, prdata, q;
	logic [8:0] ext; // async inputs of the servo side
	logic [2:0] analogSelect;
	logic [1:0] profileSelect, positionSource;
	logic [6:0] wrStb, regWriteStrobe_n;
	logic [DIST_WIDTH-1:0] distanceRegister;
	logic longSeekFlag, trackParityBit, tempSourceSelect, positionLoopEnable_n;
	logic ampEnable, cpuRetractRequest_n, sectorStartPulse, err, ok;
	int fail_count, cmp_count, n;
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	shpi_top shpi_top_i (.clk(clk), .reset(reset), .masterReset_n(masterReset_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .offTrackEvent(ext[0]),
		.sectorSyncIn(ext[1]), .dataClockPulse(ext[2]), .quarterTrackPulse(ext[3]),
		.currentOverPos(ext[4]), .currentUnderNeg(ext[5]), .emergencyCond(ext[6]),
		.emergencyLatch(ext[7]), .selfTestCond(ext[8]), .analogSelect(analogSelect),
		.longSeekFlag(longSeekFlag), .trackParityBit(trackParityBit),
		.tempSourceSelect(tempSourceSelect), .positionLoopEnable_n(positionLoopEnable_n),
		.profileSelect(profileSelect), .positionSource(positionSource),
		.ampEnable(ampEnable), .cpuRetractRequest_n(cpuRetractRequest_n),
		.distanceRegister(distanceRegister), .headAlignOffset(headAlignOffset),
		.sectorStartPulse(sectorStartPulse), .regReadStrobe_n(regReadStrobe_n),
		.regWriteStrobe_n(regWriteStrobe_n));
	shpi_cpu_model shpi_cpu_model_i (.clk(clk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));
	// ************************************************************
	// helpers
	// ************************************************************
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// strobes sampled once the completing edge has landed
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		shpi_cpu_model_i.xfer(1'b1, a, d, q, err, ok);
		#1 wrStb = regWriteStrobe_n;
		chk("ready", 1, ok);
		if (ok !== 1'b1)
			tally_and_finish();
	endtask : wr
	// registered outputs follow one edge after the write lands
	task automatic wrs(input logic [7:0] a, input logic [31:0] d);
		wr(a, d);
		@(posedge clk);
		#1;
	endtask : wrs
	task automatic rd(input logic [7:0] a);
		shpi_cpu_model_i.xfer(1'b0, a, 32'h0000_0000, q, err, ok);
		#1 rdStb = regReadStrobe_n;
		chk("ready", 1, ok);
		if (ok !== 1'b1)
			tally_and_finish();
	endtask : rd
	// pulse wide enough for the input synchronisers
	task automatic pulse(input logic [8:0] m);
		@(posedge clk);
		ext <= ext | m;
		repeat (3) @(posedge clk);
		ext <= ext & ~m;
		repeat (3) @(posedge clk);
	endtask : pulse
	// bounded poll of one status bit
	task automatic poll(input int b, input logic v);
		for (n = 0; n < 40; n++)
		begin
			rd(ADDR_STAT);
			if (q[b] === v)
				break;
		end
		chk("status bit", v, q[b]);
		if (q[b] !== v)
			tally_and_finish();
	endtask : poll
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : tally_and_finish
	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic t_ctrl;
		for (int i = 0; i < 32; i++)
		begin
			wrs(ADDR_CTRL, 32'h0000_0180 | (i[4:3] << CTRL_PROF_LO) | i[2:0] | (i[0] << 6));
			chk("wstb", 7'h7e, wrStb);
			chk("asel", i[2:0], analogSelect);
			chk("prof", i[4:3], profileSelect);
			chk("temp", i[0], tempSourceSelect);
			rd(ADDR_CTRL);
			chk("ctrl", 32'h0000_0180 | (i[4:3] << 10) | i[2:0] | (i[0] << 6), q);
			chk("rstb", 8'hfe, rdStb);
		end
		rd(ADDR_SKEWV);
		chk("rstb3", 8'hf7, rdStb);
		rd(8'h1c);
		chk("slverr", 1, err);
		$display("test ctrl done");
	endtask : t_ctrl
	task automatic t_seek;
		wrs(ADDR_CTRL, shpi_cpu_model_i.seek_bits(33, 5));
		chk("long", 1, longSeekFlag);
		chk("par", 1, trackParityBit);
		chk("src", 1, positionSource);
		chk("loop", 1, positionLoopEnable_n);
		poll(STAT_PARITY, 1'b1);
		wrs(ADDR_CTRL, shpi_cpu_model_i.seek_bits(32, 6));
		chk("short", 0, longSeekFlag);
		wrs(ADDR_CTRL, shpi_cpu_model_i.follow_bits(7));
		chk("fine", 0, positionSource);
		chk("loopon", 0, positionLoopEnable_n);
		wrs(ADDR_CTRL, 32'h0000_0080);
		chk("test", 2, positionSource);
		wrs(ADDR_OFST, 32'h0000_005a);
		chk("ofst", 8'h5a, headAlignOffset);
		rd(ADDR_OFST);
		chk("ofstrd", 32'h0000_005a, q);
		chk("rstb6", 8'hbf, rdStb);
		$display("test seek done");
	endtask : t_seek
	task automatic t_flags;
		wr(ADDR_CTRL, shpi_cpu_model_i.follow_bits(0));
		pulse(9'h001);
		poll(STAT_OFTRK, 1'b1);
		rd(ADDR_STAT);
		chk("held", 1, q[STAT_OFTRK]);
		wr(ADDR_CMD, 32'h0000_0001);
		poll(STAT_OFTRK, 1'b0);
		poll(STAT_AMPEN, 1'b1);
		chk("ampout", 1, ampEnable);
		wr(ADDR_CTRL, 32'h0000_01a0);
		poll(STAT_AMPEN, 1'b0);
		for (int b = 4; b < 8; b++)
		begin
			wr(ADDR_CTRL, 32'h0000_0180);
			ext[b] <= 1'b1;
			poll(STAT_AMPEN, !(b >= 6));
			poll(STAT_CLIM_N, !(b < 6));
			ext[b] <= 1'b0;
		end
		wr(ADDR_CMD, 32'h0000_0004);
		for (n = 0; n < 8 && cpuRetractRequest_n !== 1'b0; n++)
			@(posedge clk);
		chk("retract", 0, cpuRetractRequest_n);
		if (cpuRetractRequest_n !== 1'b0)
			tally_and_finish();
		$display("test flags done");
	endtask : t_flags
	task automatic t_dist;
		wr(ADDR_DIST, 32'hffff_ffff);
		rd(ADDR_DIST);
		chk("dist", 32'h0000_07ff, q);
		wr(ADDR_CTRL, 32'h0000_0380);
		repeat (3) pulse(9'h008);
		chk("distout", 11'h7fc, distanceRegister);
		$display("test dist done");
	endtask : t_dist
	task automatic t_skew;
		wr(ADDR_SKEWW, 32'h0000_0090);
		wr(ADDR_CTRL, 32'h0000_2180);
		poll(STAT_SKMFLG, 1'b1);
		repeat (10) @(posedge clk);
		poll(STAT_SKMFLG, 1'b1);
		pulse(9'h006);
		poll(STAT_SKMFLG, 1'b0);
		rd(ADDR_SKEWV);
		chk("skew", SKEW_ZERO, q);
		poll(STAT_SYNC, 1'b1);
		wr(ADDR_CMD, 32'h0000_0002);
		poll(STAT_SYNC, 1'b0);
		for (n = 0; n < 300 && sectorStartPulse !== 1'b1; n++)
			@(posedge clk);
		chk("sos", 1, sectorStartPulse);
		if (sectorStartPulse !== 1'b1)
			tally_and_finish();
		poll(STAT_SOSP, 1'b1);
		wr(ADDR_CMD, 32'h0000_0002);
		poll(STAT_SOSP, 1'b0);
		// a self-test condition also ends the measurement
		wr(ADDR_CTRL, 32'h0000_0180);
		wr(ADDR_CTRL, 32'h0000_2180);
		poll(STAT_SKMFLG, 1'b1);
		ext[8] <= 1'b1;
		poll(STAT_SKMFLG, 1'b0);
		ext[8] <= 1'b0;
		$display("test skew done");
	endtask : t_skew
	// ************************************************************
	// main sequence and watchdog
	// ************************************************************
	initial
	begin
		fail_count = 0;
		cmp_count = 0;
		ext = 9'h000;
		masterReset_n = 1'b1;
		reset = 1'b1;
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		rd(ADDR_CTRL);
		chk("ctrlrst", 32'h0000_0180, q);
		chk("retrrst", 1, cpuRetractRequest_n);
		t_ctrl();
		t_seek();
		t_flags();
		t_dist();
		t_skew();
		masterReset_n <= 1'b0;
		repeat (4) @(posedge clk);
		masterReset_n <= 1'b1;
		repeat (4) @(posedge clk);
		rd(ADDR_CTRL);
		chk("mrst", 32'h0000_0180, q);
		tally_and_finish();
	end
	initial
	begin
		repeat (60000) @(posedge clk);
		fail_count++;
		tally_and_finish();
	end
endmodule : shpi_top_tb_top
